// ### design/frame_cfg_regs.v
// Purpose: Bit-rate select and type-A framing configuration registers.
// Assumes: Host writes through a synchronous address/data strobe port.
// Notes:   Settings are latched into the active copy only between frames.
//
// Function
// R01 - Bits 7..4 select transmit rate: fc/128, /64, /32, /16.
// R02 - Bits 3..0 select receive rate with same coding when protocol allows.
// R03 - Unsupported code in either nibble disables transmit and receive.
// R04 - Both registers clear at power-up and on restore-defaults command.
// R05 - Normal-mode-entry command loads the bit-rate register itself.
// R06 - Bit 7 of framing register transmits without parity bits.
// R07 - Host uses transmit-without-checksum while transmit parity is suppressed.
// R08 - Bit 6 stores raw received bits, no parity or CRC check.
// R09 - Host keeps receive parity suppression clear outside type-A mode.
// R10 - Bit 5 prepends F0 and length on transmit, drops F0 on receive.
// R11 - Bits 4..1 set modulation pulse width in carrier periods.
// R12 - Width code is signed offset from per-rate base 35, 18, 9, 5.
// R13 - Host sets bit 0 before a bit-oriented anticollision frame.
// R14 - Host uses parity suppression options for custom frame formats.
// R15 - Register changes take effect only at the next frame start.
`timescale 1ns/1ps
`include "frame_cfg_consts.vh"
module frame_cfg_regs (
    input  wire                 MCLK,             // 50 MHz clock
    input  wire                 RSTN,             // Async reset, active low
    input  wire [`ADDR_W-1:0]   ADDR,             // Register address
    input  wire                 WR_EN,            // Write strobe
    input  wire                 RD_EN,            // Read strobe
    input  wire [`DATA_W-1:0]   WDATA,            // Write data
    input  wire                 RESTORE_DEFAULTS, // Restore-defaults command pulse
    input  wire                 NORMAL_MODE_ENTRY,// Normal-mode-entry command pulse
    input  wire [`DATA_W-1:0]   NORMAL_RATE,      // Rate byte loaded by that command
    input  wire                 FRAME_BUSY,       // Frame in progress
    output reg  [`DATA_W-1:0]   RDATA,            // Read data
    output reg  [3:0]           TX_SPEED_CODE,    // Active transmit rate
    output reg  [3:0]           RX_SPEED_CODE,    // Active receive rate
    output reg                  TXRX_ENABLE,      // Low on unsupported rate
    output reg                  NO_TX_PARITY,     // Suppress transmit parity
    output reg                  NO_RX_PARITY,     // Raw receive, no checks
    output reg                  TRANSPORT_HEADER_ENABLE, // Header insert/strip
    output reg  [`DATA_W-1:0]   HEADER_START_BYTE,// Start byte to insert/strip
    output reg  [5:0]           PULSE_WIDTH,      // Pulse width in carrier periods
    output reg                  ANTICOLL_FRAME    // Anticollision framing
);
    reg  [`DATA_W-1:0] bit_rate_select_ff;
    reg  [`DATA_W-1:0] typea_framing_ff;
    reg  [`DATA_W-1:0] nxt_bit_rate_select;
    reg  [`DATA_W-1:0] nxt_typea_framing;
    wire [3:0]         transmit_speed_code;
    wire [3:0]         receive_speed_code;
    wire [3:0]         pulse_width_code;
    wire [5:0]         width_periods;
    wire               rates_ok;

    assign transmit_speed_code = bit_rate_select_ff[`TX_CODE_HI:`TX_CODE_LO]; // [R01]
    assign receive_speed_code  = bit_rate_select_ff[`RX_CODE_HI:`RX_CODE_LO]; // [R02]
    assign pulse_width_code    = typea_framing_ff[`PW_CODE_HI:`PW_CODE_LO];   // [R11]
    assign rates_ok = (transmit_speed_code <= `RATE_MAX_CODE) &&
                      (receive_speed_code <= `RATE_MAX_CODE);                 // [R03]

    pulse_width_calc u_pw (
        .rate_code  (transmit_speed_code),
        .width_code (pulse_width_code),
        .periods    (width_periods)
    );

    // Restore-defaults beats every other source; the command load beats a host write.
    always @* begin
        nxt_bit_rate_select = bit_rate_select_ff;
        nxt_typea_framing   = typea_framing_ff;
        if (WR_EN && ADDR == `ADDR_BIT_RATE) begin
            nxt_bit_rate_select = WDATA;
        end
        if (WR_EN && ADDR == `ADDR_TYPEA_FRAMING) begin
            nxt_typea_framing = WDATA;
        end
        if (NORMAL_MODE_ENTRY) begin
            nxt_bit_rate_select = NORMAL_RATE; // [R05]
        end
        if (RESTORE_DEFAULTS) begin
            nxt_bit_rate_select = `RESET_BYTE; // [R04]
            nxt_typea_framing   = `RESET_BYTE; // [R04]
        end
    end

    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            bit_rate_select_ff <= `RESET_BYTE; // [R04]
            typea_framing_ff   <= `RESET_BYTE; // [R04]
            RDATA              <= `RESET_BYTE;
        end else begin
            bit_rate_select_ff <= nxt_bit_rate_select;
            typea_framing_ff   <= nxt_typea_framing;
            if (RD_EN && ADDR == `ADDR_BIT_RATE) begin
                RDATA <= bit_rate_select_ff;
            end else if (RD_EN && ADDR == `ADDR_TYPEA_FRAMING) begin
                RDATA <= typea_framing_ff;
            end else if (RD_EN) begin
                RDATA <= `RESET_BYTE;
            end
        end
    end

    // Active copies hold steady during a frame so a mid-frame write cannot corrupt it.
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            TX_SPEED_CODE           <= `RATE_DIV128;
            RX_SPEED_CODE           <= `RATE_DIV128;
            TXRX_ENABLE             <= 1'b1;
            NO_TX_PARITY            <= 1'b0;
            NO_RX_PARITY            <= 1'b0;
            TRANSPORT_HEADER_ENABLE <= 1'b0;
            HEADER_START_BYTE       <= `START_BYTE;
            PULSE_WIDTH             <= `BASE_DIV128;
            ANTICOLL_FRAME          <= 1'b0;
        end else if (!FRAME_BUSY) begin // [R15]
            TX_SPEED_CODE           <= transmit_speed_code;                  // [R01]
            RX_SPEED_CODE           <= receive_speed_code;                   // [R02]
            TXRX_ENABLE             <= rates_ok;                             // [R03]
            NO_TX_PARITY            <= typea_framing_ff[`BIT_NO_TX_PARITY];  // [R06]
            NO_RX_PARITY            <= typea_framing_ff[`BIT_NO_RX_PARITY];  // [R08]
            TRANSPORT_HEADER_ENABLE <= typea_framing_ff[`BIT_TRANSPORT_HDR]; // [R10]
            HEADER_START_BYTE       <= `START_BYTE;                          // [R10]
            PULSE_WIDTH             <= width_periods;                        // [R12]
            ANTICOLL_FRAME          <= typea_framing_ff[`BIT_ANTICOLL];
        end
    end
endmodule // frame_cfg_regs

// ### design/frame_cfg_consts.vh
// Purpose: Named constants for the bit-rate and type-A framing configuration bank.
// Assumes: 8-bit register data, 50 MHz MCLK.
// Notes:   Definitions only.
`ifndef FRAME_CFG_CONSTS_VH
`define FRAME_CFG_CONSTS_VH
`define ADDR_W              6
`define DATA_W              8
`define ADDR_BIT_RATE       6'h04
`define ADDR_TYPEA_FRAMING  6'h05
`define RESET_BYTE          8'h00
`define TX_CODE_HI          7
`define TX_CODE_LO          4
`define RX_CODE_HI          3
`define RX_CODE_LO          0
`define BIT_NO_TX_PARITY    7
`define BIT_NO_RX_PARITY    6
`define BIT_TRANSPORT_HDR   5
`define PW_CODE_HI          4
`define PW_CODE_LO          1
`define BIT_ANTICOLL        0
`define RATE_DIV128         4'h0
`define RATE_DIV64          4'h1
`define RATE_DIV32          4'h2
`define RATE_DIV16          4'h3
`define RATE_MAX_CODE       4'h3
`define BASE_DIV128         6'h23
`define BASE_DIV64          6'h12
`define BASE_DIV32          6'h09
`define BASE_DIV16          6'h05
`define START_BYTE          8'hF0
`endif

// ### design/pulse_width_calc.v
// Purpose: Converts a signed pulse-width code into carrier periods for one rate.
// Assumes: Code is two's complement, 4 bits, offset from the per-rate base.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "frame_cfg_consts.vh"
module pulse_width_calc (
    input  wire [3:0] rate_code,   // Transmit rate code
    input  wire [3:0] width_code,  // Signed width offset
    output reg  [5:0] periods      // Width in carrier periods
);
    reg [5:0] base;
    always @* begin
        case (rate_code)
            `RATE_DIV128: base = `BASE_DIV128;
            `RATE_DIV64:  base = `BASE_DIV64;
            `RATE_DIV32:  base = `BASE_DIV32;
            default:      base = `BASE_DIV16;
        endcase
        periods = base + {{2{width_code[3]}}, width_code}; // [R12]
    end
endmodule // pulse_width_calc

// ### test/frame_cfg_checker.sv
// Purpose: Port checks on the configuration bank.
// Assumes: Active copy follows a register update one edge later, outside frames.
// Notes:   Attached by bind.
`timescale 1ns/1ps
module frame_cfg_checker (
    input logic       MCLK,                    // Bank clock
    input logic       RSTN,                    // Async reset, active low
    input logic       WR_EN,                   // Write strobe
    input logic       RD_EN,                   // Read strobe
    input logic       RESTORE_DEFAULTS,        // Restore-defaults pulse
    input logic       NORMAL_MODE_ENTRY,       // Normal-mode-entry pulse
    input logic       FRAME_BUSY,              // Frame in progress
    input logic [5:0] ADDR,                    // Register address
    input logic [7:0] WDATA,                   // Write data
    input logic [7:0] NORMAL_RATE,             // Rate loaded by the command
    input logic [7:0] RDATA,                   // Read data
    input logic [7:0] HEADER_START_BYTE,       // Start byte to insert or strip
    input logic [3:0] TX_SPEED_CODE,           // Active transmit rate
    input logic [3:0] RX_SPEED_CODE,           // Active receive rate
    input logic       TXRX_ENABLE,             // Rate codes supported
    input logic       NO_TX_PARITY,            // Transmit parity off
    input logic       NO_RX_PARITY,            // Raw receive
    input logic       TRANSPORT_HEADER_ENABLE  // Header insert and strip
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence wr_at(a); WR_EN && ADDR == a && !RESTORE_DEFAULTS && !NORMAL_MODE_ENTRY; endsequence
    sequence rd_at(a); RD_EN && ADDR == a && !WR_EN && !RESTORE_DEFAULTS && !NORMAL_MODE_ENTRY; endsequence
    sequence free; !FRAME_BUSY && !RESTORE_DEFAULTS && !NORMAL_MODE_ENTRY && !WR_EN; endsequence
    rate_gate_a: assert property (TXRX_ENABLE == (TX_SPEED_CODE <= 4'h3 && RX_SPEED_CODE <= 4'h3))
        else $error("enable disagrees with rates");
    rate_load_a: assert property (wr_at(6'h04) ##1 free |=> {TX_SPEED_CODE, RX_SPEED_CODE} == $past(WDATA, 2))
        else $error("rate codes not loaded");
    flags_load_a: assert property (wr_at(6'h05) ##1 free |=>
        {NO_TX_PARITY, NO_RX_PARITY, TRANSPORT_HEADER_ENABLE} == $past(WDATA[7:5], 2)) else $error("flags not loaded");
    busy_hold_a: assert property (FRAME_BUSY |=>
        $stable({TX_SPEED_CODE, RX_SPEED_CODE, TXRX_ENABLE, NO_TX_PARITY, NO_RX_PARITY, TRANSPORT_HEADER_ENABLE}))
        else $error("settings moved in a frame");
    header_byte_a: assert property (HEADER_START_BYTE == 8'hF0) else $error("start byte wrong");
    restore_clear_a: assert property (RESTORE_DEFAULTS ##1 rd_at(6'h05) |=> RDATA == 8'h00)
        else $error("restore left data");
    normal_load_a: assert property (NORMAL_MODE_ENTRY && !RESTORE_DEFAULTS ##1 rd_at(6'h04) |=>
        RDATA == $past(NORMAL_RATE, 2)) else $error("normal rate not loaded");
    rate_read_a: assert property (wr_at(6'h04) ##1 rd_at(6'h04) |=> RDATA == $past(WDATA, 2))
        else $error("rate readback wrong");
endmodule // frame_cfg_checker
bind frame_cfg_regs frame_cfg_checker u_chk (
    .MCLK(MCLK), .RSTN(RSTN), .WR_EN(WR_EN), .RD_EN(RD_EN), .RESTORE_DEFAULTS(RESTORE_DEFAULTS),
    .NORMAL_MODE_ENTRY(NORMAL_MODE_ENTRY), .FRAME_BUSY(FRAME_BUSY), .ADDR(ADDR), .WDATA(WDATA),
    .NORMAL_RATE(NORMAL_RATE), .RDATA(RDATA), .HEADER_START_BYTE(HEADER_START_BYTE),
    .TX_SPEED_CODE(TX_SPEED_CODE), .RX_SPEED_CODE(RX_SPEED_CODE), .TXRX_ENABLE(TXRX_ENABLE),
    .NO_TX_PARITY(NO_TX_PARITY), .NO_RX_PARITY(NO_RX_PARITY),
    .TRANSPORT_HEADER_ENABLE(TRANSPORT_HEADER_ENABLE));

// ### test/cfg_host_model.sv
// Purpose: Host side of the register strobe port.
// Assumes: One request a cycle, launched at the falling edge.
// Notes:   Command pulses come from the bench.
`timescale 1ns/1ps
module cfg_host_model (
    input  logic       clk,   // Bench clock
    output logic [5:0] addr,  // Register address
    output logic       wr_en, // Write strobe
    output logic       rd_en, // Read strobe
    output logic [7:0] wdata  // Write data
);
    initial {addr, wr_en, rd_en, wdata} = '0;
    // Idle data is inverted so a stale byte never looks like a valid write.
    task op(input logic w, r, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = w;
        rd_en = r;
        addr = a;
        wdata = w ? d : ~wdata;
    endtask
endmodule // cfg_host_model

// ### test/bitrate_and_typea_framing_config_test.sv
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Inputs change at the falling edge.
// Notes:   Random bytes from a fixed seed.
`timescale 1ns/1ps
module bitrate_and_typea_framing_config_test;
    logic MCLK = 0, RSTN = 0, RESTORE_DEFAULTS = 0, NORMAL_MODE_ENTRY = 0, FRAME_BUSY = 0, WR_EN, RD_EN;
    logic [5:0] ADDR, PULSE_WIDTH;
    logic [7:0] WDATA, RDATA, NORMAL_RATE = 0, HEADER_START_BYTE, v4, v5, o4, o5;
    logic [3:0] TX_SPEED_CODE, RX_SPEED_CODE;
    logic TXRX_ENABLE, NO_TX_PARITY, NO_RX_PARITY, TRANSPORT_HEADER_ENABLE, ANTICOLL_FRAME;
    int fails = 0, total_checks = 0, seed = 32'h8515, p;
    always #10 MCLK = ~MCLK;
    cfg_host_model host (.clk(MCLK), .addr(ADDR), .wr_en(WR_EN), .rd_en(RD_EN), .wdata(WDATA));
    frame_cfg_regs u_dut (
        .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .WDATA(WDATA),
        .RESTORE_DEFAULTS(RESTORE_DEFAULTS), .NORMAL_MODE_ENTRY(NORMAL_MODE_ENTRY), .NORMAL_RATE(NORMAL_RATE),
        .FRAME_BUSY(FRAME_BUSY), .RDATA(RDATA), .TX_SPEED_CODE(TX_SPEED_CODE), .RX_SPEED_CODE(RX_SPEED_CODE),
        .TXRX_ENABLE(TXRX_ENABLE), .NO_TX_PARITY(NO_TX_PARITY), .NO_RX_PARITY(NO_RX_PARITY),
        .TRANSPORT_HEADER_ENABLE(TRANSPORT_HEADER_ENABLE), .HEADER_START_BYTE(HEADER_START_BYTE),
        .PULSE_WIDTH(PULSE_WIDTH), .ANTICOLL_FRAME(ANTICOLL_FRAME));
    task chk(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task act_chk(logic [7:0] b4, logic [7:0] b5);
        p = (b4[7:4] == 0 ? 35 : b4[7:4] == 1 ? 18 : b4[7:4] == 2 ? 9 : 5) + $signed(b5[4:1]);
        chk(TXRX_ENABLE, b4[7:4] < 4 && b4[3:0] < 4);
        chk({TX_SPEED_CODE, RX_SPEED_CODE}, b4);
        chk({NO_TX_PARITY, NO_RX_PARITY, TRANSPORT_HEADER_ENABLE, ANTICOLL_FRAME}, {b5[7:5], b5[0]});
        if (p > 0) chk(PULSE_WIDTH, p[7:0]);
    endtask
    task idle; host.op(0, 0, 0, 0); endtask
    task final_report;
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge MCLK);
        fails++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge MCLK);
        @(negedge MCLK) RSTN = 1;
        act_chk(0, 0);
        for (int i = 0; i < 32; i++) begin
            v4 = 8'($random(seed)) & (i[0] ? 8'h33 : 8'hFF);
            v5 = 8'($random(seed));
            host.op(1, 0, 5, v5);
            idle;
            host.op(1, 0, 4, v4);
            host.op(0, 1, 4, 0);
            host.op(0, 1, 5, 0);
            chk(RDATA, v4);
            idle;
            chk(RDATA, v5);
            act_chk(v4, v5);
        end
        {o4, o5, v4, v5} = {v4, v5, 16'h21FF};
        FRAME_BUSY = 1;
        host.op(1, 0, 4, v4);
        host.op(1, 0, 5, v5);
        idle;
        act_chk(o4, o5);
        FRAME_BUSY = 0;
        idle;
        act_chk(v4, v5);
        RESTORE_DEFAULTS = 1;
        host.op(0, 1, 5, 0);
        RESTORE_DEFAULTS = 0;
        idle;
        chk(RDATA, 0);
        idle;
        act_chk(0, 0);
        NORMAL_RATE = 8'($random(seed)) & 8'h33;
        NORMAL_MODE_ENTRY = 1;
        host.op(0, 1, 4, 0);
        NORMAL_MODE_ENTRY = 0;
        host.op(1, 0, 6'h06, 8'hFF);
        host.op(0, 1, 6'h3F, 0);
        chk(RDATA, NORMAL_RATE);
        host.op(0, 1, 4, 0);
        chk(RDATA, 0);
        idle;
        chk(RDATA, NORMAL_RATE);
        act_chk(NORMAL_RATE, 0);
        // A reset in mid-run must clear both registers, the framing byte before the active copy picks it up.
        host.op(1, 0, 5, 8'h5A);
        idle;
        RSTN = 0;
        idle;
        RSTN = 1;
        act_chk(0, 0);
        host.op(0, 1, 5, 0);
        host.op(0, 1, 4, 0);
        chk(RDATA, 0);
        idle;
        chk(RDATA, 0);
        final_report;
    end
endmodule // bitrate_and_typea_framing_config_test
